/* File: verilog/bfap_host.v */
// What this block does
// - Fresh select falling edge for every access
// - Select stays high at least 60 ns
// - Select stays low at least 70 ns
// - Write strobe rises 70 ns after select
// - Write strobe held low at least 40 ns
// - Select not taken low while supply is low
`timescale 1ns/10ps
`include "bfap_consts.vh"
module bfap_host #(
    parameter AW        = `BFAP_ADDR_W,
    parameter DW        = `BFAP_DATA_W,
    parameter CW        = `BFAP_CNT_W,
    parameter PRE_NS    = `BFAP_PRECHARGE_NS,
    parameter ACT_NS    = `BFAP_ACTIVE_NS,
    parameter SW_NS     = `BFAP_SEL_TO_WR_NS,
    parameter WP_NS     = `BFAP_WR_LOW_NS,
    parameter ACC_NS    = `BFAP_ACCESS_NS
) (
    input  wire          clk_in,
    input  wire          nrst_in,
    input  wire          supply_ok_in,
    input  wire          req_valid_in,
    input  wire          req_write_in,
    input  wire [AW-1:0] req_addr_in,
    input  wire [DW-1:0] req_wdata_in,
    output reg           req_ready_out,
    output reg           rsp_valid_out,
    output reg  [DW-1:0] rsp_rdata_out,
    output reg  [AW-4:0] rsp_row_out,
    output reg           mem_select_n_out,
    output reg           mem_write_n_out,
    output reg           mem_drive_n_out,
    output reg  [AW-1:0] mem_addr_out,
    input  wire [DW-1:0] mem_dq_in,
    output reg  [DW-1:0] mem_dq_out,
    output reg           mem_dq_oe_out
);
    // Least times round up to whole cycles
    localparam integer PRE_I = (PRE_NS + `BFAP_CLK_PERIOD_NS - 1) / `BFAP_CLK_PERIOD_NS;
    localparam integer ACT_I = (ACT_NS + `BFAP_CLK_PERIOD_NS - 1) / `BFAP_CLK_PERIOD_NS;
    localparam integer SW_I  = (SW_NS + `BFAP_CLK_PERIOD_NS - 1) / `BFAP_CLK_PERIOD_NS;
    localparam integer WP_I  = (WP_NS + `BFAP_CLK_PERIOD_NS - 1) / `BFAP_CLK_PERIOD_NS;
    localparam integer ACC_I = (ACC_NS + `BFAP_CLK_PERIOD_NS - 1) / `BFAP_CLK_PERIOD_NS;

    // One select window serves reads and writes alike, so it must cover
    // the active time, the select-to-strobe-release time and the access time
    localparam integer SW_ACT = (SW_I > ACT_I) ? SW_I : ACT_I;
    localparam integer WIN_I  = (ACC_I > SW_ACT) ? ACC_I : SW_ACT;

    localparam [CW-1:0] ONE     = {{(CW-1){1'b0}}, 1'b1};
    localparam [CW-1:0] PRE_CYC = PRE_I[CW-1:0];
    localparam [CW-1:0] WIN_CYC = WIN_I[CW-1:0];
    // Strobe falls at this count, one above the pulse width as release comes at count one, so it spans a full pulse
    localparam [CW-1:0] WR_FALL = WP_I[CW-1:0] + ONE;

    // One-hot states
    localparam [3:0] ST_IDLE   = 4'b0001;
    localparam [3:0] ST_ACTIVE = 4'b0010;
    localparam [3:0] ST_PRE    = 4'b0100;
    localparam [3:0] ST_HOLD   = 4'b1000;

    reg [3:0]    state;
    reg          is_write;
    reg [CW-1:0] act_left;
    reg          pre_load;
    wire         pre_done;
    wire         take;
    wire         act_end;
    wire         wr_start;

    // Request accepted only in idle with supply good
    assign take     = (state == ST_IDLE) && supply_ok_in && req_valid_in;
    // Last cycle of the select window
    assign act_end  = (state == ST_ACTIVE) && (act_left == ONE);
    // Strobe goes low a full pulse width before the window closes
    assign wr_start = (state == ST_ACTIVE) && is_write && (act_left == WR_FALL);

    // Precharge counted by the shared timer block
    bfap_timer #(
        .W        (CW)
    ) u_pre (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .load_in  (pre_load),
        .count_in (PRE_CYC),
        .done_out (pre_done)
    );

    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state            <= ST_HOLD;
            is_write         <= 1'b0;
            act_left         <= {CW{1'b0}};
            pre_load         <= 1'b0;
            req_ready_out    <= 1'b0;
            mem_select_n_out <= 1'b1;
            mem_write_n_out  <= 1'b1;
            mem_drive_n_out  <= 1'b1;
            mem_addr_out     <= {AW{1'b0}};
        end
        else
        begin
            pre_load <= 1'b0;
            case (state)
                ST_HOLD:
                begin
                    // Select parked high until supply is good
                    mem_select_n_out <= 1'b1;
                    req_ready_out    <= 1'b0;
                    if (supply_ok_in && pre_done)
                    begin
                        state         <= ST_IDLE;
                        req_ready_out <= 1'b1;
                    end
                end

                ST_IDLE:
                begin
                    if (!supply_ok_in)
                    begin
                        state         <= ST_HOLD;
                        req_ready_out <= 1'b0;
                    end
                    else if (take)
                    begin
                        // Address is set up with the falling select edge
                        mem_addr_out     <= req_addr_in;
                        mem_select_n_out <= 1'b0;
                        is_write         <= req_write_in;
                        // Memory drives only on reads, never against our data
                        mem_drive_n_out  <= req_write_in;
                        // Strobe high at select fall, so writes are strobe-timed
                        mem_write_n_out  <= 1'b1;
                        act_left         <= WIN_CYC;
                        req_ready_out    <= 1'b0;
                        state            <= ST_ACTIVE;
                    end
                end

                ST_ACTIVE:
                begin
                    act_left <= act_left - ONE;
                    if (wr_start)
                        mem_write_n_out <= 1'b0;
                    if (act_end)
                    begin
                        // Strobe and select rise together, data still held
                        mem_write_n_out  <= 1'b1;
                        mem_select_n_out <= 1'b1;
                        mem_drive_n_out  <= 1'b1;
                        pre_load         <= 1'b1;
                        state            <= ST_PRE;
                    end
                end

                ST_PRE:
                begin
                    // Wait one extra cycle for the timer load to land
                    if (!pre_load && pre_done)
                    begin
                        state         <= supply_ok_in ? ST_IDLE : ST_HOLD;
                        req_ready_out <= supply_ok_in;
                    end
                end

                default:
                begin
                    state            <= ST_HOLD;
                    mem_select_n_out <= 1'b1;
                end
            endcase
        end
    end

    // Write data stays on the pins one cycle past select, giving data hold
    // Reads release the pins in the same edge that hands them to the memory
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            mem_dq_out    <= {DW{1'b0}};
            mem_dq_oe_out <= 1'b0;
        end
        else if (take)
        begin
            mem_dq_out    <= req_wdata_in;
            mem_dq_oe_out <= req_write_in;
        end
        else if (state == ST_PRE)
            mem_dq_oe_out <= 1'b0;
    end

    // Response side kept apart from the pin sequencer
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= {DW{1'b0}};
            rsp_row_out   <= {(AW-`BFAP_ROW_LSB){1'b0}};
        end
        else
        begin
            rsp_valid_out <= act_end;
            // Row worn by this access, reported with the request
            if (take)
                rsp_row_out <= req_addr_in[AW-1:`BFAP_ROW_LSB];
            // Data sampled as select rises, access time already met
            if (act_end && !is_write)
                rsp_rdata_out <= mem_dq_in;
        end
    end
endmodule

/* File: pkg/bfap_consts.vh */
`ifndef BFAP_CONSTS_VH
`define BFAP_CONSTS_VH
`define BFAP_ADDR_W        13
`define BFAP_DATA_W        8
`define BFAP_CLK_PERIOD_NS 10
`define BFAP_PRECHARGE_NS  60
`define BFAP_ACTIVE_NS     70
`define BFAP_SEL_TO_WR_NS  70
`define BFAP_WR_LOW_NS     40
`define BFAP_ACCESS_NS     70
`define BFAP_ROW_LSB       3
`define BFAP_CNT_W         4
`endif

/* File: verilog/bfap_timer.v */
`timescale 1ns/10ps
module bfap_timer #(
    parameter W = 4
) (
    input  wire         clk_in,
    input  wire         nrst_in,
    input  wire         load_in,
    input  wire [W-1:0] count_in,
    output wire         done_out
);
    reg [W-1:0] remain;

    assign done_out = (remain == {W{1'b0}});

    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            remain <= {W{1'b0}};
        else if (load_in)
            remain <= count_in;
        else if (remain != {W{1'b0}})
            remain <= remain - {{(W-1){1'b0}}, 1'b1};
    end
endmodule

/* File: dv/bfap_mem_model.sv */
`timescale 1ns/10ps
module bfap_mem_model (
    input  wire        sel_n_in,
    input  wire        wr_n_in,
    input  wire        drv_n_in,
    input  wire [12:0] a_in,
    input  wire [7:0]  d_in,
    output reg  [7:0]  d_out = 8'h5a,
    output reg         bad_out = 1'b0
);
    reg [7:0]  mem [0:8191];
    reg [12:0] a;
    reg        wr;
    reg        ok;
    reg        wip = 1'b0;
    realtime   tf = -1000;
    realtime   tr = 0;
    // A falling select starts a cycle, except one within 65 ns of the last, missed while the block waits
    always @(negedge sel_n_in)
    begin
        a = a_in;
        wr = !wr_n_in;
        ok = $realtime - tr >= 60;
        bad_out = bad_out | !ok;
        wip = wr;
        tf = $realtime;
        d_out = ~d_out;
        #65;
        if (!sel_n_in && !wr && !drv_n_in && wr_n_in)
            d_out = mem[a];
    end
    // Strobe falling inside select opens the array write
    always @(negedge wr_n_in)
    begin
        if (!sel_n_in)
            wip = 1'b1;
    end
    // First rising edge closes it; a same-step pair writes only once
    always @(posedge sel_n_in or posedge wr_n_in)
    begin
        if (wip && ok && $realtime - tf >= 70)
            mem[a] = d_in;
        wip = 1'b0;
    end
    always @(posedge sel_n_in)
    begin
        tr = $realtime;
        bad_out = bad_out | ($realtime - tf < 70);
        d_out = ~d_out;
    end
endmodule

/* File: dv/bfap_host_props.sv */
`timescale 1ns/10ps
module bfap_host_props (
    input wire clk_in,
    input wire nrst_in,
    input wire supply_ok_in,
    input wire req_valid_in,
    input wire req_ready_out,
    input wire rsp_valid_out,
    input wire mem_select_n_out,
    input wire mem_write_n_out,
    input wire mem_drive_n_out,
    input wire mem_dq_oe_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_take; req_valid_in && req_ready_out; endsequence
    sequence s_cyc; $fell(mem_select_n_out) ##7 $rose(mem_select_n_out); endsequence
    property p_fresh; s_take |-> ##1 s_cyc; endproperty
    a_fresh: assert property (p_fresh) else $error("cycle");
    property p_pre; $rose(mem_select_n_out) |-> mem_select_n_out [*6]; endproperty
    a_pre: assert property (p_pre) else $error("precharge");
    property p_act; $fell(mem_select_n_out) |-> !mem_select_n_out [*7]; endproperty
    a_act: assert property (p_act) else $error("active");
    property p_cw; $rose(mem_write_n_out) |-> !$past(mem_select_n_out, 7); endproperty
    a_cw: assert property (p_cw) else $error("strobe early");
    property p_wp; $fell(mem_write_n_out) |-> !mem_write_n_out [*4]; endproperty
    a_wp: assert property (p_wp) else $error("strobe short");
    property p_sup; !supply_ok_in && mem_select_n_out |=> mem_select_n_out; endproperty
    a_sup: assert property (p_sup) else $error("supply");
    property p_rsp; $rose(mem_select_n_out) |-> rsp_valid_out; endproperty
    a_rsp: assert property (p_rsp) else $error("response");
    property p_rdy; s_take |-> ##2 !req_ready_out [*8]; endproperty
    a_rdy: assert property (p_rdy) else $error("ready");
    property p_cont; mem_dq_oe_out |-> mem_drive_n_out; endproperty
    a_cont: assert property (p_cont) else $error("bus contention");
    property p_wsel; !mem_write_n_out |-> !mem_select_n_out; endproperty
    a_wsel: assert property (p_wsel) else $error("strobe outside select");
endmodule
bind bfap_host bfap_host_props u_props (.clk_in(clk_in), .nrst_in(nrst_in),
    .supply_ok_in(supply_ok_in), .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
    .rsp_valid_out(rsp_valid_out), .mem_select_n_out(mem_select_n_out),
    .mem_write_n_out(mem_write_n_out), .mem_drive_n_out(mem_drive_n_out),
    .mem_dq_oe_out(mem_dq_oe_out));

/* File: dv/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    reg         clk_in, nrst_in, supply_ok_in, req_valid_in, req_write_in;
    reg  [12:0] req_addr_in, ad;
    reg  [7:0]  req_wdata_in, shadow [0:8191];
    reg  [8191:0] known;
    wire        req_ready_out, rsp_valid_out, mem_select_n_out, mem_write_n_out;
    wire        mem_drive_n_out, mem_dq_oe_out, fault;
    wire [7:0]  rsp_rdata_out, mem_dq_out, mdq;
    wire [9:0]  rsp_row_out;
    wire [12:0] mem_addr_out;
    wire [7:0]  mem_dq_in = mem_dq_oe_out ? mem_dq_out : mdq;
    integer     mismatches, comparisons, i, n;
    bfap_host u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .supply_ok_in(supply_ok_in),
        .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_addr_in(req_addr_in),
        .req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out),
        .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out),
        .rsp_row_out(rsp_row_out), .mem_select_n_out(mem_select_n_out),
        .mem_write_n_out(mem_write_n_out), .mem_drive_n_out(mem_drive_n_out),
        .mem_addr_out(mem_addr_out), .mem_dq_in(mem_dq_in), .mem_dq_out(mem_dq_out),
        .mem_dq_oe_out(mem_dq_oe_out));
    bfap_mem_model u_mem (.sel_n_in(mem_select_n_out), .wr_n_in(mem_write_n_out),
        .drv_n_in(mem_drive_n_out), .a_in(mem_addr_out), .d_in(mem_dq_in),
        .d_out(mdq), .bad_out(fault));
    function [9:0] row(input [12:0] a);
        row = a[12:3];
    endfunction
    task wrap_up;
    begin
        if (mismatches == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask
    task chk(input [63:0] nm, input [15:0] e, input [15:0] s);
    begin
        comparisons = comparisons + 1;
        if (e !== s)
        begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED %0s exp %h got %h", nm, e, s);
        end
    end
    endtask
    task tick;
    begin
        @(posedge clk_in);
        #1 n = n + 1;
        if (n > 60)
        begin
            mismatches = mismatches + 1;
            wrap_up;
        end
    end
    endtask
    task acc(input w, input [12:0] a, input [7:0] d);
    begin
        n = 0;
        while (req_ready_out !== 1'b1)
            tick;
        {req_valid_in, req_write_in, req_addr_in, req_wdata_in} = {1'b1, w, a, d};
        tick;
        req_valid_in = 0;
        req_addr_in = $urandom;
        while (rsp_valid_out !== 1'b1)
            tick;
        chk("row", row(a), rsp_row_out);
        chk("addr", a, mem_addr_out);
        if (w)
            {known[a], shadow[a]} = {1'b1, d};
        else if (known[a])
            chk("rdata", shadow[a], rsp_rdata_out);
    end
    endtask
    initial
    begin
        clk_in = 0;
        forever #5 clk_in = ~clk_in;
    end
    initial
    begin
        {nrst_in, supply_ok_in, req_valid_in, req_write_in} = 4'h4;
        {req_addr_in, req_wdata_in, known, mismatches, comparisons} = 0;
        ad = $urandom(32'h5af9);
        repeat (8) @(posedge clk_in);
        #1 nrst_in = 1;
        // Row edges and one mid-row address, written then read back to back
        for (i = 0; i < 8; i = i + 1)
            acc(!i[0], i[1] ? (i[2] ? 13'h1fff : 13'h0008) : {10'h000, i[2], 2'b11} & 13'h0007,
                $urandom);
        repeat (40)
            acc($urandom % 2, $urandom % 32, $urandom);
        supply_ok_in = 0;
        n = 0;
        repeat (2) tick;
        req_valid_in = 1;
        repeat (20)
        begin
            tick;
            chk("sel_n", 1, mem_select_n_out);
            chk("ready", 0, req_ready_out);
        end
        {req_valid_in, supply_ok_in} = 2'b01;
        acc(0, 13'h1fff, 0);
        chk("fault", 0, fault);
        wrap_up;
    end
endmodule
